/* tcer_consts.svh */
// Offsets, field positions, masks and reset values of the trace configuration and event registers
`ifndef TCER_CONSTS_SVH
`define TCER_CONSTS_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses on the register port)
// ----------------------------------------------------------------------
`define TCER_ADDR_W            12
`define TCER_OFF_CONFIG        12'h010
`define TCER_OFF_AUX           12'h018
`define TCER_OFF_EVSEL         12'h020
`define TCER_OFF_EVCTL         12'h024

// ----------------------------------------------------------------------
// Writable masks, read-as-one bits and reset values
// ----------------------------------------------------------------------
`define TCER_CONFIG_MASK       32'h0003_1f5e
`define TCER_CONFIG_RAO        32'h0000_0001
`define TCER_AUX_MASK          32'h0000_0003
`define TCER_EVSEL_MASK        32'h8f8f_8f8f
`define TCER_EVCTL_MASK        32'h0000_181f
`define TCER_CONFIG_RESET      32'h0000_0000
`define TCER_AUX_RESET         32'h0000_0000
`define TCER_EVSEL_RESET       32'h0000_0000
`define TCER_EVCTL_RESET       32'h0000_0000

// ----------------------------------------------------------------------
// Trace configuration fields
// ----------------------------------------------------------------------
`define TCER_CFG_DATA_VALUE    17
`define TCER_CFG_DATA_ADDR     16
`define TCER_CFG_RET_STACK     12
`define TCER_CFG_TIMESTAMP     11
`define TCER_CFG_CONDITIONAL_TRACE_SELECT_HI       10
`define TCER_CFG_CONDITIONAL_TRACE_SELECT_LO       8
`define TCER_CFG_CONTEXT_ID    6
`define TCER_CFG_CYCLE_COUNT   4
`define TCER_CFG_BRANCH_BCAST  3
`define TCER_CFG_P0_HI         2
`define TCER_CFG_P0_LO         1

// ----------------------------------------------------------------------
// Auxiliary control and event fields
// ----------------------------------------------------------------------
`define TCER_AUX_QUICK_FLUSH   1
`define TCER_AUX_SYNC_OVF      0
`define TCER_EV_STRIDE         8
`define TCER_EV_TYPE_POS       7
`define TCER_EV_SEL_W          4
`define TCER_EV_COUNT          4
`define TCER_EVC_LPO           12
`define TCER_EVC_TRIG          11
`define TCER_EVC_DATA_EVENT    4

`endif

/* tcer_pkg.sv */
// Types shared by the trace configuration and event register block
package tcer_pkg;

  typedef enum logic [2:0] {
    TCER_CONDITIONAL_TRACE_SELECT_NONE  = 3'h0,
    TCER_CONDITIONAL_TRACE_SELECT_LOAD  = 3'h1,
    TCER_CONDITIONAL_TRACE_SELECT_STORE = 3'h2,
    TCER_CONDITIONAL_TRACE_SELECT_LDST  = 3'h3,
    TCER_CONDITIONAL_TRACE_SELECT_ALL   = 3'h7
  } tcer_conditional_trace_select_t;

  typedef enum logic [0:0] {
    TCER_SYNC_IDLE    = 1'b0,
    TCER_SYNC_PENDING = 1'b1
  } tcer_sync_t;

  // One retired instruction as offered by the core
  typedef struct packed {
    logic valid;
    logic isBranch;
    logic isLoad;
    logic isStore;
    logic isCond;
    logic dataAddrValid;
    logic dataValueValid;
    logic contextIdValid;
  } tcer_instr_t;

  // Trace items to produce for that instruction
  typedef struct packed {
    logic valid;
    logic isP0;
    logic emitDataAddr;
    logic emitDataValue;
    logic emitContextId;
  } tcer_trace_t;

  // Static mode levels for the trace generator
  typedef struct packed {
    logic returnStackEnable;
    logic timestampEnable;
    logic cycleCountEnable;
    logic branchBroadcastEnable;
  } tcer_mode_t;

endpackage

/* tcer_event_sel.sv */
// Resource selector for one trace event
`timescale 1ns/1ps
`default_nettype none

module tcer_event_sel
  import tcer_pkg::*;
(
  input  wire logic        resourceType,
  input  wire logic [3:0]  resourceNumber,
  input  wire logic [15:0] singleResources,
  input  wire logic [7:0]  pairResources,
  output logic             eventHit
);

  // Pair mode looks only at the low three selector bits
  always_comb
  begin
    if (resourceType)
      eventHit = pairResources[resourceNumber[2:0]];
    else
      eventHit = singleResources[resourceNumber];
  end

endmodule

`default_nettype wire

/* tcer_trace_filter.sv */
// Classifies retired instructions and gates trace items by configuration
`timescale 1ns/1ps
`default_nettype none

module tcer_trace_filter
  import tcer_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire tcer_instr_t instr,
  input  wire logic        dataValueEnable,
  input  wire logic        dataAddressEnable,
  input  wire logic        contextIdEnable,
  input  wire logic [2:0]  conditionalTraceSelect,
  input  wire logic [1:0]  pZeroClassSelect,
  output tcer_trace_t      traceItem
);

  // ----------------------------------------------------------------------
  // Classification
  // ----------------------------------------------------------------------
  // Reserved encodings trace no conditional instruction
  function automatic logic condTraced(input logic [2:0] mode, input logic ld, input logic st);
    logic r;
    r = 1'b0;
    if (mode == TCER_CONDITIONAL_TRACE_SELECT_ALL)
      r = 1'b1;
    else if (mode[2] == 1'b0)
      r = (mode[0] & ld) | (mode[1] & st);
    return r;
  endfunction

  logic traced;
  assign traced = instr.valid &
                  (!instr.isCond | condTraced(conditionalTraceSelect, instr.isLoad,
                                              instr.isStore));

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      traceItem <= '0;
    else
    begin
      traceItem.valid         <= traced;
      traceItem.isP0          <= traced & (instr.isBranch |
                                 (pZeroClassSelect[0] & instr.isLoad) |
                                 (pZeroClassSelect[1] & instr.isStore));
      traceItem.emitDataValue <= traced & instr.dataValueValid & dataValueEnable;
      traceItem.emitDataAddr  <= traced & instr.dataAddrValid & dataAddressEnable;
      traceItem.emitContextId <= traced & instr.contextIdValid & contextIdEnable;
    end
  end

  AST_P0_CLASS: assert property (@(posedge mclk) disable iff (!arst_n)
    instr.valid && !instr.isCond && !instr.isBranch && instr.isLoad && !instr.isStore
    |=> traceItem.isP0 == $past(pZeroClassSelect[0]))
    else $error("load classified against p-zero select");

  AST_CONDITIONAL_TRACE_SELECT_ALL: assert property (@(posedge mclk) disable iff (!arst_n)
    instr.valid && instr.isCond && conditionalTraceSelect == TCER_CONDITIONAL_TRACE_SELECT_ALL
    |=> traceItem.valid)
    else $error("conditional instruction dropped in all mode");

endmodule

`default_nettype wire

/* tcer_regs.sv */
// Trace configuration and event control register bank with its gating logic
`timescale 1ns/1ps
`default_nettype none
`include "tcer_consts.svh"

module tcer_regs
  import tcer_pkg::*;
(
  input  wire logic                      mclk,
  input  wire logic                      arst_n,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [`TCER_ADDR_W-1:0]   paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      programEnable,
  input  wire logic                      drainBusy,
  output logic                           traceClockEnable,
  output logic                           traceInterfaceEnablePin,
  input  wire tcer_instr_t               instr,
  output tcer_trace_t                    traceItem,
  output tcer_mode_t                     traceMode,
  input  wire logic [15:0]               singleResources,
  input  wire logic [7:0]                pairResources,
  input  wire logic                      lowPowerState,
  output logic                           resourceFreeze,
  output logic [3:0]                     extEventOut,
  output logic [3:0]                     instEventElem,
  output logic [3:0]                     dataEventElem,
  input  wire logic                      triggerRequest,
  output logic                           busTrigger,
  input  wire logic                      flushRequest,
  input  wire logic                      fifoEmpty,
  input  wire logic                      waitForInterrupt,
  output logic                           flushReady,
  input  wire logic                      syncDue,
  input  wire logic                      syncDone,
  output logic                           overflowForce
);

  // ----------------------------------------------------------------------
  // Register port decode
  // ----------------------------------------------------------------------
  logic [31:0] traceConfig_reg;
  logic [31:0] auxControl_reg;
  logic [31:0] eventSelect_reg;
  logic [31:0] eventControl_reg;

  function automatic logic isMapped(input logic [`TCER_ADDR_W-1:0] a);
    logic r;
    r = 1'b0;
    if (a == `TCER_OFF_CONFIG)
      r = 1'b1;
    else if (a == `TCER_OFF_AUX)
      r = 1'b1;
    else if (a == `TCER_OFF_EVSEL)
      r = 1'b1;
    else if (a == `TCER_OFF_EVCTL)
      r = 1'b1;
    return r;
  endfunction

  logic accessPhase;
  logic setupRead;
  logic writeStrobe;
  assign accessPhase = psel & penable;
  assign setupRead   = psel & !penable & !pwrite;
  // Writes while tracing is not being programmed are dropped
  assign writeStrobe = accessPhase & pwrite & programEnable & isMapped(paddr);

  assign pready  = 1'b1;
  assign pslverr = accessPhase & !isMapped(paddr);

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      traceConfig_reg <= `TCER_CONFIG_RESET;
    else if (writeStrobe && paddr == `TCER_OFF_CONFIG)
      traceConfig_reg <= pwdata & `TCER_CONFIG_MASK;
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      auxControl_reg <= `TCER_AUX_RESET;
    else if (writeStrobe && paddr == `TCER_OFF_AUX)
      auxControl_reg <= pwdata & `TCER_AUX_MASK;
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      eventSelect_reg <= `TCER_EVSEL_RESET;
    else if (writeStrobe && paddr == `TCER_OFF_EVSEL)
      eventSelect_reg <= pwdata & `TCER_EVSEL_MASK;
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      eventControl_reg <= `TCER_EVCTL_RESET;
    else if (writeStrobe && paddr == `TCER_OFF_EVCTL)
      eventControl_reg <= pwdata & `TCER_EVCTL_MASK;
  end

  // Read data is captured in the setup phase so it stands for the access phase
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      prdata <= 32'h0000_0000;
    else if (setupRead)
    begin
      if (paddr == `TCER_OFF_CONFIG)
        prdata <= traceConfig_reg | `TCER_CONFIG_RAO;
      else if (paddr == `TCER_OFF_AUX)
        prdata <= auxControl_reg;
      else if (paddr == `TCER_OFF_EVSEL)
        prdata <= eventSelect_reg;
      else if (paddr == `TCER_OFF_EVCTL)
        prdata <= eventControl_reg;
      else
        prdata <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------------
  // Clock request and interface pin
  // ----------------------------------------------------------------------
  assign traceClockEnable = programEnable | psel | drainBusy;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      traceInterfaceEnablePin <= 1'b0;
    else
      traceInterfaceEnablePin <= programEnable;
  end

  // ----------------------------------------------------------------------
  // Trace item gating
  // ----------------------------------------------------------------------
  tcer_trace_filter u_filter (
    .mclk                   (mclk),
    .arst_n                 (arst_n),
    .instr                  (instr),
    .dataValueEnable        (traceConfig_reg[`TCER_CFG_DATA_VALUE]),
    .dataAddressEnable      (traceConfig_reg[`TCER_CFG_DATA_ADDR]),
    .contextIdEnable        (traceConfig_reg[`TCER_CFG_CONTEXT_ID]),
    .conditionalTraceSelect (traceConfig_reg[`TCER_CFG_CONDITIONAL_TRACE_SELECT_HI:`TCER_CFG_CONDITIONAL_TRACE_SELECT_LO]),
    .pZeroClassSelect       (traceConfig_reg[`TCER_CFG_P0_HI:`TCER_CFG_P0_LO]),
    .traceItem              (traceItem)
  );

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      traceMode <= '0;
    else
    begin
      traceMode.returnStackEnable     <= traceConfig_reg[`TCER_CFG_RET_STACK];
      traceMode.timestampEnable       <= traceConfig_reg[`TCER_CFG_TIMESTAMP];
      traceMode.cycleCountEnable      <= traceConfig_reg[`TCER_CFG_CYCLE_COUNT];
      traceMode.branchBroadcastEnable <= traceConfig_reg[`TCER_CFG_BRANCH_BCAST];
    end
  end

  // ----------------------------------------------------------------------
  // Event selection
  // ----------------------------------------------------------------------
  logic [3:0] eventHit;
  logic       lowPowerGate;
  logic [3:0] eventLive;

  for (genvar e = 0; e < `TCER_EV_COUNT; e++)
  begin : g_event
    tcer_event_sel u_sel (
      .resourceType    (eventSelect_reg[e*`TCER_EV_STRIDE + `TCER_EV_TYPE_POS]),
      .resourceNumber  (eventSelect_reg[e*`TCER_EV_STRIDE +: `TCER_EV_SEL_W]),
      .singleResources (singleResources),
      .pairResources   (pairResources),
      .eventHit        (eventHit[e])
    );
  end

  // Without the override, entering low power silences resources and events
  assign lowPowerGate   = lowPowerState & !eventControl_reg[`TCER_EVC_LPO];
  assign resourceFreeze = lowPowerGate;
  assign eventLive      = lowPowerGate ? 4'h0 : eventHit;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      extEventOut   <= 4'h0;
      instEventElem <= 4'h0;
      dataEventElem <= 4'h0;
    end
    else
    begin
      extEventOut   <= eventLive;
      instEventElem <= eventLive & eventControl_reg[3:0];
      dataEventElem <= eventLive & {4{eventControl_reg[`TCER_EVC_DATA_EVENT]}};
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      busTrigger <= 1'b0;
    else
      busTrigger <= triggerRequest & eventControl_reg[`TCER_EVC_TRIG];
  end

  // ----------------------------------------------------------------------
  // Flush answer
  // ----------------------------------------------------------------------
  // Quick mode trades trace kept in the buffer for an immediate answer
  assign flushReady = flushRequest &
                      (auxControl_reg[`TCER_AUX_QUICK_FLUSH] |
                       (fifoEmpty & !waitForInterrupt));

  // ----------------------------------------------------------------------
  // Synchronisation tracking
  // ----------------------------------------------------------------------
  tcer_sync_t syncState_reg;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      syncState_reg <= TCER_SYNC_IDLE;
    else
    begin
      case (syncState_reg)
        TCER_SYNC_IDLE:
          if (syncDue && !syncDone)
            syncState_reg <= TCER_SYNC_PENDING;
        TCER_SYNC_PENDING:
          // A new request in the cycle of completion keeps the block pending
          if (syncDone && !syncDue)
            syncState_reg <= TCER_SYNC_IDLE;
        default:
          syncState_reg <= TCER_SYNC_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      overflowForce <= 1'b0;
    else
      overflowForce <= auxControl_reg[`TCER_AUX_SYNC_OVF] & syncDue & !syncDone &
                       (syncState_reg == TCER_SYNC_PENDING);
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence sDueWhilePending;
    syncState_reg == TCER_SYNC_PENDING && syncDue && !syncDone;
  endsequence

  sequence sConfigRead;
    setupRead && paddr == `TCER_OFF_CONFIG ##1 accessPhase;
  endsequence

  AST_SYNC_OVERFLOW: assert property (@(posedge mclk) disable iff (!arst_n)
    sDueWhilePending and auxControl_reg[`TCER_AUX_SYNC_OVF] |=> overflowForce)
    else $error("missing forced overflow");

  AST_NO_OVERFLOW_OFF: assert property (@(posedge mclk) disable iff (!arst_n)
    !auxControl_reg[`TCER_AUX_SYNC_OVF] |=> !overflowForce)
    else $error("overflow forced while disabled");

  AST_RESERVED_ZERO: assert property (@(posedge mclk) disable iff (!arst_n)
    sConfigRead |-> (prdata & ~(`TCER_CONFIG_MASK | `TCER_CONFIG_RAO)) == 32'h0 && prdata[0])
    else $error("reserved configuration bits not zero");

  AST_WRITE_IGNORED: assert property (@(posedge mclk) disable iff (!arst_n)
    accessPhase && pwrite && !programEnable |=> $stable(traceConfig_reg) &&
    $stable(eventSelect_reg) && $stable(eventControl_reg) && $stable(auxControl_reg))
    else $error("write taken while program enable low");

  AST_DV_GATE: assert property (@(posedge mclk) disable iff (!arst_n)
    traceItem.emitDataValue |-> $past(traceConfig_reg[`TCER_CFG_DATA_VALUE]))
    else $error("data value trace while disabled");

  AST_DA_GATE: assert property (@(posedge mclk) disable iff (!arst_n)
    traceItem.emitDataAddr |-> $past(traceConfig_reg[`TCER_CFG_DATA_ADDR]))
    else $error("data address trace while disabled");

  AST_CID_GATE: assert property (@(posedge mclk) disable iff (!arst_n)
    traceItem.emitContextId |-> $past(traceConfig_reg[`TCER_CFG_CONTEXT_ID]))
    else $error("context id trace while disabled");

  AST_LOW_POWER: assert property (@(posedge mclk) disable iff (!arst_n)
    lowPowerState && !eventControl_reg[`TCER_EVC_LPO] |=> extEventOut == 4'h0)
    else $error("event escaped low power");

  AST_EXT_EVENT: assert property (@(posedge mclk) disable iff (!arst_n)
    !lowPowerState && eventHit[0] |=> extEventOut[0] &&
    instEventElem[0] == $past(eventControl_reg[0]))
    else $error("event zero not driven");

  AST_TRIGGER: assert property (@(posedge mclk) disable iff (!arst_n)
    busTrigger |-> $past(eventControl_reg[`TCER_EVC_TRIG]) && $past(triggerRequest))
    else $error("trigger without enable");

  AST_FLUSH_WAIT: assert property (@(posedge mclk) disable iff (!arst_n)
    flushRequest && !auxControl_reg[`TCER_AUX_QUICK_FLUSH] && !fifoEmpty |-> !flushReady)
    else $error("flush answered before drain");

  AST_RS_MODE: assert property (@(posedge mclk) disable iff (!arst_n)
    ##1 traceMode.returnStackEnable == $past(traceConfig_reg[`TCER_CFG_RET_STACK]))
    else $error("return stack mode not following register");

endmodule

`default_nettype wire

/* tcer_core_model.sv */
// Stand-in for the traced core: retired instructions, resources, power and sync strobes
`timescale 1ns/1ps
`default_nettype none

module tcer_core_model
  import tcer_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic [31:0] rnd,
  output tcer_instr_t      instr,
  output logic [15:0]      singleResources,
  output logic [7:0]       pairResources,
  output logic             lowPowerState,
  output logic             waitForInterrupt,
  output logic             syncDue,
  output logic             syncDone
);
  initial {instr, singleResources, pairResources} = '0;
  initial {lowPowerState, waitForInterrupt, syncDue, syncDone} = '0;
  // Updates land after the falling edge so the block samples settled values
  always @(negedge mclk)
  begin
    instr           <= rnd[7:0];
    singleResources <= rnd[23:8];
    pairResources   <= rnd[31:24];
    {lowPowerState, waitForInterrupt, syncDue, syncDone} <= rnd[27:24] ^ rnd[11:8];
  end
endmodule
`default_nettype wire

/* testbench.sv */
// Self-checking bench for the trace configuration and event register block
`timescale 1ns/1ps
`default_nettype none
`include "tcer_consts.svh"

module testbench
  import tcer_pkg::*;
;
  logic        mclk, arst_n, psel, penable, pwrite, programEnable, drainBusy;
  logic        flushRequest, fifoEmpty, triggerRequest, pendM, trigM, ovfM, pinM;
  logic        lowPowerState, waitForInterrupt, syncDue, syncDone, pready, pslverr;
  logic        traceClockEnable, traceInterfaceEnablePin, resourceFreeze, busTrigger;
  logic        flushReady, overflowForce;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rnd, cfgM, auxM, evsM, evcM, rdExp;
  logic [3:0]  hitM, extM, instM, datM, extEventOut, instEventElem, dataEventElem;
  logic [15:0] singleResources;
  logic [7:0]  pairResources;
  tcer_instr_t instr;
  tcer_trace_t itemM, traceItem;
  tcer_mode_t  modeM, traceMode;
  int          mismatches, n_compared;
  logic [11:0] offs [5] = '{`TCER_OFF_CONFIG, `TCER_OFF_AUX, `TCER_OFF_EVSEL,
                            `TCER_OFF_EVCTL, 12'h014};
  logic [2:0]  conds [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};

  tcer_core_model tcer_core_model_inst (.mclk, .rnd, .instr, .singleResources,
    .pairResources, .lowPowerState, .waitForInterrupt, .syncDue, .syncDone);
  tcer_regs tcer_regs_inst (.mclk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .programEnable, .drainBusy, .traceClockEnable,
    .traceInterfaceEnablePin, .instr, .traceItem, .traceMode, .singleResources,
    .pairResources, .lowPowerState, .resourceFreeze, .extEventOut, .instEventElem,
    .dataEventElem, .triggerRequest, .busTrigger, .flushRequest, .fifoEmpty,
    .waitForInterrupt, .flushReady, .syncDue, .syncDone, .overflowForce);

  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  function automatic logic [31:0] rv(input logic [11:0] a);
    case (a)
      `TCER_OFF_CONFIG: return cfgM | `TCER_CONFIG_RAO;
      `TCER_OFF_AUX:    return auxM;
      `TCER_OFF_EVSEL:  return evsM;
      `TCER_OFF_EVCTL:  return evcM;
      default:          return 32'h0000_0000;
    endcase
  endfunction

  function automatic tcer_trace_t filt(input tcer_instr_t i, input logic [31:0] c);
    logic s, v;
    s = (c[10:8] == 3'h7) | (c[8] & i.isLoad) | (c[9] & i.isStore);
    v = i.valid & (!i.isCond | s);
    return {v, v & (i.isBranch | (c[1] & i.isLoad) | (c[2] & i.isStore)),
            v & i.dataAddrValid & c[16], v & i.dataValueValid & c[17],
            v & i.contextIdValid & c[6]};
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(negedge mclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
    @(negedge mclk);
    penable <= 1'b1;
    rdExp = rv(a);
    @(negedge mclk);
    if (!wr) chk("prdata", prdata, rdExp);
    {psel, penable} <= 2'b00;
  endtask

  task automatic complete_run();
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Reference model: registered results use register values from before the edge
  // ----------------------------------------------------------------------
  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      {cfgM, auxM, evsM, evcM, pendM, trigM, ovfM, pinM, extM, instM, datM, itemM, modeM} = '0;
    else
    begin
      for (int e = 0; e < 4; e++)
        hitM[e] = evsM[8*e+7] ? pairResources[evsM[8*e+:3]] : singleResources[evsM[8*e+:4]];
      extM = (lowPowerState && !evcM[12]) ? 4'h0 : hitM;
      instM = extM & evcM[3:0];
      datM = extM & {4{evcM[4]}};
      trigM = triggerRequest & evcM[11];
      ovfM = syncDue & pendM & !syncDone & auxM[0];
      pendM = pendM ? (syncDue | !syncDone) : (syncDue & !syncDone);
      pinM = programEnable;
      modeM = {cfgM[12], cfgM[11], cfgM[4], cfgM[3]};
      itemM = filt(instr, cfgM);
      if (psel && penable && pwrite && programEnable)
        case (paddr)
          `TCER_OFF_CONFIG: cfgM = pwdata & `TCER_CONFIG_MASK;
          `TCER_OFF_AUX:    auxM = pwdata & `TCER_AUX_MASK;
          `TCER_OFF_EVSEL:  evsM = pwdata & `TCER_EVSEL_MASK;
          `TCER_OFF_EVCTL:  evcM = pwdata & `TCER_EVCTL_MASK;
          default:          ;
        endcase
    end
  end

  // Compare before this edge's new inputs land, then launch the next random set
  always @(negedge mclk)
  begin
    if (arst_n)
    begin
      chk("traceItem", traceItem, itemM);
      chk("traceMode", traceMode, modeM);
      chk("extEventOut", extEventOut, extM);
      chk("instEventElem", instEventElem, instM);
      chk("dataEventElem", dataEventElem, datM);
      chk("busTrigger", busTrigger, trigM);
      chk("overflowForce", overflowForce, ovfM);
      chk("flushReady", flushReady,
          flushRequest & (auxM[1] | (fifoEmpty & !waitForInterrupt)));
      chk("resourceFreeze", resourceFreeze, lowPowerState & !evcM[12]);
      chk("pslverr", pslverr, psel & penable & (rv(paddr) === 32'h0 & paddr == 12'h014));
      chk("clocks", {traceInterfaceEnablePin, traceClockEnable},
          {pinM, programEnable | psel | drainBusy});
      chk("pready", pready, 1'b1);
    end
    rnd <= xs(rnd);
    {flushRequest, fifoEmpty, triggerRequest, drainBusy} <= rnd[15:12];
  end

  initial
  begin
    {arst_n, psel, penable, pwrite, paddr, pwdata, programEnable} = '0;
    {flushRequest, fifoEmpty, triggerRequest, drainBusy} = '0;
    rnd = 32'h05dd;
    mismatches = 0;
    n_compared = 0;
    repeat (10) @(negedge mclk);
    arst_n <= 1'b1;
    for (int k = 0; k < 5; k++) apb(1'b0, offs[k], 32'h0);
    // Program enable still low, so these writes must leave every register alone
    for (int k = 0; k < 5; k++) apb(1'b1, offs[k], 32'hffff_ffff);
    for (int n = 0; n < 12; n++)
    begin
      programEnable <= (n != 6);
      // Only defined conditional codes are written
      apb(1'b1, offs[0], {rnd[31:11], conds[n % 5], rnd[7:0]} | {32{n == 11}});
      for (int k = 1; k < 5; k++) apb(1'b1, offs[k], rnd | {32{n == 11}});
      repeat (20) @(negedge mclk);
      for (int k = 0; k < 5; k++) apb(1'b0, offs[k], 32'h0);
    end
    complete_run();
  end

  initial
  begin
    #20000;
    mismatches++;
    complete_run();
  end
endmodule
`default_nettype wire
